// file: design/caa_cfg.svh
`ifndef CAA_CFG_SVH
`define CAA_CFG_SVH

// Register byte offsets on the bus
`define CAA_AW          8
`define CAA_OFF_CTRL    8'h00
`define CAA_OFF_AL1_SP  8'h04
`define CAA_OFF_AL1_CFG 8'h08
`define CAA_OFF_AL2_SP  8'h0c
`define CAA_OFF_AL2_CFG 8'h10
`define CAA_OFF_RNG_LO  8'h14
`define CAA_OFF_RNG_MID 8'h18
`define CAA_OFF_RNG_TOP 8'h1c
`define CAA_OFF_STATUS  8'h20
`define CAA_OFF_CONC    8'h24
`define CAA_OFF_AOUT    8'h28

// Control register fields
`define CAA_CTRL_MODE_LSB 0
`define CAA_CTRL_CAL      2
`define CAA_CTRL_STBY     3

// Reset values, ppm oxygen
`define CAA_SP_RST      24'h0003e8
`define CAA_RNG_LO_RST  24'h000064
`define CAA_RNG_MID_RST 24'h0003e8
`define CAA_RNG_TOP_RST 24'h002710
`define CAA_CAL_TOP     24'h03d090
`define CAA_CFG_RST     4'h0

`endif

// file: design/caa_pkg.sv
package caa_pkg;

	typedef enum logic [1:0]
	{
		CAA_RNG_LO  = 2'h0,
		CAA_RNG_MID = 2'h1,
		CAA_RNG_TOP = 2'h2,
		CAA_RNG_CAL = 2'h3
	} caa_rng_t;

	typedef enum logic [1:0]
	{
		CAA_AUTO_RANGE       = 2'h0,
		CAA_FORCED_LOW_RANGE = 2'h1,
		CAA_FORCED_MID_RANGE = 2'h2,
		CAA_FORCED_TOP_RANGE = 2'h3
	} caa_mode_t;

	typedef enum logic [1:0]
	{
		CAA_DIV_IDLE = 2'b01,
		CAA_DIV_BUSY = 2'b10
	} caa_div_t;

	typedef struct packed
	{
		logic latch;
		logic relay_deenergize_on_alarm;
		logic defeat;
		logic below_setpoint_dir;
	} caa_alarm_cfg_t;

endpackage

// file: design/caa_conc_alarm_autorange.sv
// What this block does
// - two concentration alarms plus system alarm, own relays
// - high alarm trips above set point
// - low alarm trips below set point
// - failsafe relay de-energised while alarm active
// - non-failsafe relay energised while alarm active
// - latching alarm holds until explicitly reset
// - non-latching alarm follows the condition
// - defeat suppresses the alarm
// - defeat toggle or latch re-arm clears latch
// - five settings per alarm, each writable
// - three ranges, defaults 100, 1000, 10000 ppm
// - automatic ranging after reset
// - auto mode steps up past range top
// - auto mode steps down below lower top
// - range change updates scaling and range id
// - auto or forced low, mid, top range
// - fixed range overflow saturates analog output
// - true concentration reported regardless of range
// - range tops must strictly increase
// - every range starts at zero ppm
// - air calibration uses fixed 0-25 percent
// - standby on then off clears cell failure
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
`include "caa_cfg.svh"

module caa_conc_alarm_autorange
#(
	parameter int CONC_W = 24,
	parameter int AOUT_W = 16
)
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              arst_n_i,
	// AHB-Lite slave
	input  wire logic              hsel_i,
	input  wire logic [31:0]       haddr_i,
	input  wire logic [1:0]        htrans_i,
	input  wire logic              hwrite_i,
	input  wire logic [2:0]        hsize_i,
	input  wire logic [31:0]       hwdata_i,
	input  wire logic              hready_i,
	output logic      [31:0]       hrdata_o,
	output logic                   hreadyout_o,
	output logic                   hresp_o,
	// Measurement
	input  wire logic [CONC_W-1:0] conc_i,
	input  wire logic              conc_valid_i,
	input  wire logic              cell_fail_i,
	// Relays and analog output
	output logic                   relay_conc_alarm_one_o,
	output logic                   relay_conc_alarm_two_o,
	output logic                   relay_sys_alarm_o,
	output logic      [1:0]        range_id_o,
	output logic      [AOUT_W-1:0] aout_o,
	output logic                   aout_sat_o,
	output logic      [CONC_W-1:0] conc_o
);

	localparam int CW = $clog2(AOUT_W + 1);

	logic                      wr_pend_r;
	logic [`CAA_AW-1:0]        wr_addr_r;
	logic [31:0]               hrdata_r;
	logic                      hreadyout_r;
	logic                      hresp_r;
	logic [31:0]               rd_val;
	logic [CONC_W-1:0]         wv;
	logic                      wr_ctrl;
	logic [1:0]                wr_sp;
	logic [1:0]                wr_cfg;
	logic [2:0]                wr_rng;
	caa_pkg::caa_mode_t        mode_r;
	logic                      cal_r;
	logic                      stby_r;
	logic [CONC_W-1:0]         sp_r [2];
	caa_pkg::caa_alarm_cfg_t   cfg_r [2];
	caa_pkg::caa_alarm_cfg_t   nw_cfg;
	logic [CONC_W-1:0]         top_r [3];
	logic                      reject_r;
	logic [1:0]                act_r;
	logic [1:0]                cond;
	logic [1:0]                clr;
	logic [2:0]                relay_r;
	logic                      cellfail_r;
	caa_pkg::caa_rng_t         rng_r;
	logic [CONC_W-1:0]         conc_r;
	logic                      smp_d_r;
	logic [CONC_W-1:0]         cur_top;
	logic [CONC_W-1:0]         low_top;
	caa_pkg::caa_div_t         div_st;
	logic [CONC_W:0]           rem_r;
	logic [AOUT_W-1:0]         q_r;
	logic [CW-1:0]             cnt_r;
	logic [AOUT_W-1:0]         aout_r;
	logic                      sat_r;
	logic [CONC_W:0]           rem2;

	function automatic logic trips(
		input logic [CONC_W-1:0] c,
		input logic [CONC_W-1:0] sp,
		input logic              below
	);
		trips = below ? (c < sp) : (c > sp);
	endfunction

	function automatic logic [31:0] zx(input logic [CONC_W-1:0] v);
		zx = 32'(v);
	endfunction

	// Bus slave: zero wait, always OKAY
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wr_pend_r   <= 1'b0;
			wr_addr_r   <= '0;
			hrdata_r    <= '0;
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end
		else
		begin
			wr_pend_r   <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
			wr_addr_r   <= haddr_i[`CAA_AW-1:0];
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
			if (hsel_i && hready_i && htrans_i[1] && !hwrite_i)
				hrdata_r <= rd_val;
		end
	end

	always_comb
	begin
		rd_val = '0;
		if (haddr_i[`CAA_AW-1:0] == `CAA_OFF_CTRL)
			rd_val = 32'({stby_r, cal_r, mode_r});
		else if (haddr_i[`CAA_AW-1:0] == `CAA_OFF_AL1_SP)
			rd_val = zx(sp_r[0]);
		else if (haddr_i[`CAA_AW-1:0] == `CAA_OFF_AL1_CFG)
			rd_val = 32'(cfg_r[0]);
		else if (haddr_i[`CAA_AW-1:0] == `CAA_OFF_AL2_SP)
			rd_val = zx(sp_r[1]);
		else if (haddr_i[`CAA_AW-1:0] == `CAA_OFF_AL2_CFG)
			rd_val = 32'(cfg_r[1]);
		else if (haddr_i[`CAA_AW-1:0] == `CAA_OFF_RNG_LO)
			rd_val = zx(top_r[0]);
		else if (haddr_i[`CAA_AW-1:0] == `CAA_OFF_RNG_MID)
			rd_val = zx(top_r[1]);
		else if (haddr_i[`CAA_AW-1:0] == `CAA_OFF_RNG_TOP)
			rd_val = zx(top_r[2]);
		else if (haddr_i[`CAA_AW-1:0] == `CAA_OFF_STATUS)
			rd_val = 32'({sat_r, reject_r, cellfail_r, rng_r,
				relay_r, act_r});
		else if (haddr_i[`CAA_AW-1:0] == `CAA_OFF_CONC)
			rd_val = zx(conc_r);
		else if (haddr_i[`CAA_AW-1:0] == `CAA_OFF_AOUT)
			rd_val = 32'(aout_r);
	end

	always_comb
	begin
		wv      = hwdata_i[CONC_W-1:0];
		nw_cfg  = caa_pkg::caa_alarm_cfg_t'(hwdata_i[3:0]);
		wr_ctrl = wr_pend_r && wr_addr_r == `CAA_OFF_CTRL;
		wr_sp   = {wr_pend_r && wr_addr_r == `CAA_OFF_AL2_SP,
			wr_pend_r && wr_addr_r == `CAA_OFF_AL1_SP};
		wr_cfg  = {wr_pend_r && wr_addr_r == `CAA_OFF_AL2_CFG,
			wr_pend_r && wr_addr_r == `CAA_OFF_AL1_CFG};
		wr_rng  = {wr_pend_r && wr_addr_r == `CAA_OFF_RNG_TOP,
			wr_pend_r && wr_addr_r == `CAA_OFF_RNG_MID,
			wr_pend_r && wr_addr_r == `CAA_OFF_RNG_LO};
	end

	// Control: mode, calibration, standby
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			mode_r <= caa_pkg::CAA_AUTO_RANGE;
			cal_r  <= 1'b0;
			stby_r <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			mode_r <= caa_pkg::caa_mode_t'(
				hwdata_i[`CAA_CTRL_MODE_LSB +: 2]);
			cal_r  <= hwdata_i[`CAA_CTRL_CAL];
			stby_r <= hwdata_i[`CAA_CTRL_STBY];
		end
	end

	// Alarm settings
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			for (int i = 0; i < 2; i++)
			begin
				sp_r[i]  <= `CAA_SP_RST;
				cfg_r[i] <= `CAA_CFG_RST;
			end
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (wr_sp[i])
					sp_r[i] <= wv;
				if (wr_cfg[i])
					cfg_r[i] <= nw_cfg;
			end
		end
	end

	// Range tops; lower limit is always zero
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			top_r[0] <= `CAA_RNG_LO_RST;
			top_r[1] <= `CAA_RNG_MID_RST;
			top_r[2] <= `CAA_RNG_TOP_RST;
			reject_r <= 1'b0;
		end
		else if (wr_rng[0])
		begin
			if (wv != '0 && wv < top_r[1])
			begin
				top_r[0] <= wv;
				reject_r <= 1'b0;
			end
			else
				reject_r <= 1'b1;
		end
		else if (wr_rng[1])
		begin
			if (wv > top_r[0] && wv < top_r[2])
			begin
				top_r[1] <= wv;
				reject_r <= 1'b0;
			end
			else
				reject_r <= 1'b1;
		end
		else if (wr_rng[2])
		begin
			if (wv > top_r[1])
			begin
				top_r[2] <= wv;
				reject_r <= 1'b0;
			end
			else
				reject_r <= 1'b1;
		end
	end

	// Alarm state, one per concentration alarm
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			cond[i] = trips(conc_i, sp_r[i],
				cfg_r[i].below_setpoint_dir);
			clr[i]  = wr_cfg[i] && (nw_cfg.defeat
				|| (nw_cfg.latch && !cfg_r[i].latch));
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			act_r <= '0;
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (cfg_r[i].defeat)
					act_r[i] <= 1'b0;
				else if (conc_valid_i)
					act_r[i] <= cond[i] | (cfg_r[i].latch
						& act_r[i] & ~clr[i]);
				else if (clr[i])
					act_r[i] <= 1'b0;
			end
		end
	end

	// Cell failure latch; a new failure wins over the clear
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			cellfail_r <= 1'b0;
		else if (cell_fail_i)
			cellfail_r <= 1'b1;
		else if (wr_ctrl && stby_r && !hwdata_i[`CAA_CTRL_STBY])
			cellfail_r <= 1'b0;
	end

	// Relay drive; the system relay is always failsafe
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			relay_r <= '0;
		else
		begin
			for (int i = 0; i < 2; i++)
				relay_r[i] <= cfg_r[i].relay_deenergize_on_alarm
					? ~act_r[i] : act_r[i];
			relay_r[2] <= ~cellfail_r;
		end
	end

	// Range selection, one step per sample in auto mode
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rng_r <= caa_pkg::CAA_RNG_LO;
		else if (conc_valid_i)
		begin
			if (cal_r)
				rng_r <= caa_pkg::CAA_RNG_CAL;
			else
			begin
				case (mode_r)
					caa_pkg::CAA_FORCED_LOW_RANGE:
						rng_r <= caa_pkg::CAA_RNG_LO;
					caa_pkg::CAA_FORCED_MID_RANGE:
						rng_r <= caa_pkg::CAA_RNG_MID;
					caa_pkg::CAA_FORCED_TOP_RANGE:
						rng_r <= caa_pkg::CAA_RNG_TOP;
					default:
					begin
						if (rng_r == caa_pkg::CAA_RNG_CAL)
							rng_r <= caa_pkg::CAA_RNG_LO;
						else if (rng_r != caa_pkg::CAA_RNG_TOP
							&& conc_i > cur_top)
							rng_r <= caa_pkg::caa_rng_t'(rng_r + 2'h1);
						else if (rng_r != caa_pkg::CAA_RNG_LO
							&& conc_i < low_top)
							rng_r <= caa_pkg::caa_rng_t'(rng_r - 2'h1);
					end
				endcase
			end
		end
	end

	always_comb
	begin
		cur_top = `CAA_CAL_TOP;
		low_top = top_r[0];
		case (rng_r)
			caa_pkg::CAA_RNG_LO:  cur_top = top_r[0];
			caa_pkg::CAA_RNG_MID: cur_top = top_r[1];
			caa_pkg::CAA_RNG_TOP:
			begin
				cur_top = top_r[2];
				low_top = top_r[1];
			end
			default:              cur_top = `CAA_CAL_TOP;
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			conc_r  <= '0;
			smp_d_r <= 1'b0;
		end
		else
		begin
			smp_d_r <= conc_valid_i;
			if (conc_valid_i)
				conc_r <= conc_i;
		end
	end

	// Percent-of-range scaling: fraction conc/top by long division
	assign rem2 = {rem_r[CONC_W-1:0], 1'b0};

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			div_st <= caa_pkg::CAA_DIV_IDLE;
			rem_r  <= '0;
			q_r    <= '0;
			cnt_r  <= '0;
			aout_r <= '0;
			sat_r  <= 1'b0;
		end
		else if (smp_d_r)
		begin
			if (conc_r >= cur_top)
			begin
				aout_r <= '1;
				sat_r  <= conc_r > cur_top;
				div_st <= caa_pkg::CAA_DIV_IDLE;
			end
			else
			begin
				rem_r  <= {1'b0, conc_r};
				cnt_r  <= CW'(AOUT_W);
				q_r    <= '0;
				sat_r  <= 1'b0;
				div_st <= caa_pkg::CAA_DIV_BUSY;
			end
		end
		else
		begin
			case (div_st)
				caa_pkg::CAA_DIV_BUSY:
				begin
					if (cnt_r == '0)
					begin
						aout_r <= q_r;
						div_st <= caa_pkg::CAA_DIV_IDLE;
					end
					else
					begin
						if (rem2 >= {1'b0, cur_top})
						begin
							rem_r <= rem2 - {1'b0, cur_top};
							q_r   <= {q_r[AOUT_W-2:0], 1'b1};
						end
						else
						begin
							rem_r <= rem2;
							q_r   <= {q_r[AOUT_W-2:0], 1'b0};
						end
						cnt_r <= cnt_r - CW'(1);
					end
				end
				default:
					div_st <= caa_pkg::CAA_DIV_IDLE;
			endcase
		end
	end

	assign hrdata_o               = hrdata_r;
	assign hreadyout_o            = hreadyout_r;
	assign hresp_o                = hresp_r;
	assign relay_conc_alarm_one_o = relay_r[0];
	assign relay_conc_alarm_two_o = relay_r[1];
	assign relay_sys_alarm_o      = relay_r[2];
	assign range_id_o             = rng_r;
	assign aout_o                 = aout_r;
	assign aout_sat_o             = sat_r;
	assign conc_o                 = conc_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	property p_hi_trip;
		conc_valid_i && !cfg_r[0].defeat && !cfg_r[0].below_setpoint_dir
			&& conc_i > sp_r[0] |=> act_r[0];
	endproperty
	a_hi_trip: assert property (p_hi_trip)
		else $error("high alarm did not trip");

	property p_lo_trip;
		conc_valid_i && !cfg_r[1].defeat && cfg_r[1].below_setpoint_dir
			&& conc_i < sp_r[1] |=> act_r[1];
	endproperty
	a_lo_trip: assert property (p_lo_trip)
		else $error("low alarm did not trip");

	property p_failsafe;
		act_r[0] && cfg_r[0].relay_deenergize_on_alarm
			&& $stable(cfg_r[0]) |=> !relay_conc_alarm_one_o;
	endproperty
	a_failsafe: assert property (p_failsafe)
		else $error("failsafe relay energised in alarm");

	property p_nonfailsafe;
		act_r[1] && !cfg_r[1].relay_deenergize_on_alarm
			&& $stable(cfg_r[1]) |=> relay_conc_alarm_two_o;
	endproperty
	a_nonfailsafe: assert property (p_nonfailsafe)
		else $error("non-failsafe relay idle in alarm");

	property p_latch_hold;
		act_r[0] && cfg_r[0].latch && !cfg_r[0].defeat && !wr_cfg[0]
			|=> act_r[0];
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latched alarm dropped");

	property p_unlatch;
		conc_valid_i && !cfg_r[0].latch && !cond[0] |=> !act_r[0];
	endproperty
	a_unlatch: assert property (p_unlatch)
		else $error("non-latching alarm stuck");

	property p_defeat;
		cfg_r[0].defeat [*2] |-> !act_r[0];
	endproperty
	a_defeat: assert property (p_defeat)
		else $error("defeated alarm active");

	property p_step_up;
		conc_valid_i && !cal_r && mode_r == caa_pkg::CAA_AUTO_RANGE
			&& rng_r == caa_pkg::CAA_RNG_LO && conc_i > top_r[0]
			|=> rng_r == caa_pkg::CAA_RNG_MID;
	endproperty
	a_step_up: assert property (p_step_up)
		else $error("auto range did not step up");

	property p_step_down;
		conc_valid_i && !cal_r && mode_r == caa_pkg::CAA_AUTO_RANGE
			&& rng_r == caa_pkg::CAA_RNG_TOP && conc_i < top_r[1]
			|=> rng_r == caa_pkg::CAA_RNG_MID;
	endproperty
	a_step_down: assert property (p_step_down)
		else $error("auto range did not step down");

	property p_saturate;
		conc_valid_i && !cal_r && mode_r == caa_pkg::CAA_FORCED_LOW_RANGE
			&& conc_i > top_r[0] && !wr_rng[0]
			|-> ##2 (aout_o == '1 && aout_sat_o);
	endproperty
	a_saturate: assert property (p_saturate)
		else $error("fixed range overflow not saturated");

	property p_reject;
		wr_rng[2] && wv <= top_r[1] |=> $stable(top_r[2]) && reject_r;
	endproperty
	a_reject: assert property (p_reject)
		else $error("non-increasing range accepted");

	property p_cal;
		conc_valid_i && cal_r |=> range_id_o == caa_pkg::CAA_RNG_CAL;
	endproperty
	a_cal: assert property (p_cal)
		else $error("calibration range not selected");

endmodule

// file: tb/caa_load_model.sv
`timescale 1ns/1ns

module caa_load_model
(
	// Relay coils and analog code
	input  wire logic        coil_one_i,
	input  wire logic        coil_two_i,
	input  wire logic        coil_sys_i,
	input  wire logic [15:0] aout_i,
	// Contact state and analog level
	output logic      [2:0]  contact_closed_o,
	output logic      [10:0] aout_mv_o
);

	// Normally-open contacts close while the coil is energised
	assign contact_closed_o = {coil_sys_i, coil_two_i, coil_one_i};

	// Full code is 1 V on the voltage output
	assign aout_mv_o = 11'((32'(aout_i) * 32'h3e8) / 32'hffff);

endmodule

// file: tb/caa_conc_alarm_autorange_tb_top.sv
`timescale 1ns/1ns
`include "caa_cfg.svh"

module caa_conc_alarm_autorange_tb_top;

	logic        clk_i;
	logic        arst_n_i;
	logic        hsel_i;
	logic [31:0] haddr_i;
	logic [1:0]  htrans_i;
	logic        hwrite_i;
	logic [31:0] hwdata_i;
	logic [31:0] hrdata_o;
	logic        hready;
	logic        hresp;
	logic [23:0] conc_i;
	logic        conc_valid_i;
	logic        cell_fail_i;
	logic        rly_one;
	logic        rly_two;
	logic        rly_sys;
	logic [1:0]  range_id_o;
	logic [15:0] aout_o;
	logic        aout_sat_o;
	logic [23:0] conc_o;
	logic [2:0]  contact;
	logic [10:0] mv;
	logic [31:0] rd;
	int          miscompares;
	int          compares;

	caa_conc_alarm_autorange uut
	(
		.clk_i                  (clk_i),
		.arst_n_i               (arst_n_i),
		.hsel_i                 (hsel_i),
		.haddr_i                (haddr_i),
		.htrans_i               (htrans_i),
		.hwrite_i               (hwrite_i),
		.hsize_i                (3'h2),
		.hwdata_i               (hwdata_i),
		.hready_i               (hready),
		.hrdata_o               (hrdata_o),
		.hreadyout_o            (hready),
		.hresp_o                (hresp),
		.conc_i                 (conc_i),
		.conc_valid_i           (conc_valid_i),
		.cell_fail_i            (cell_fail_i),
		.relay_conc_alarm_one_o (rly_one),
		.relay_conc_alarm_two_o (rly_two),
		.relay_sys_alarm_o      (rly_sys),
		.range_id_o             (range_id_o),
		.aout_o                 (aout_o),
		.aout_sat_o             (aout_sat_o),
		.conc_o                 (conc_o)
	);

	caa_load_model load
	(
		.coil_one_i       (rly_one),
		.coil_two_i       (rly_two),
		.coil_sys_i       (rly_sys),
		.aout_i           (aout_o),
		.contact_closed_o (contact),
		.aout_mv_o        (mv)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One single transfer; waits on hready in both phases
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel_i   <= 1'b1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i  <= {24'h0, a};
		@(posedge clk_i);
		while (hready !== 1'b1)
			@(posedge clk_i);
		hsel_i   <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		@(posedge clk_i);
		while (hready !== 1'b1)
			@(posedge clk_i);
		rd = hrdata_o;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	// Sample spacing covers the longest analog update
	task automatic smp(input logic [23:0] c);
		@(posedge clk_i);
		conc_i       <= c;
		conc_valid_i <= 1'b1;
		@(posedge clk_i);
		conc_valid_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		#1;
	endtask

	task automatic chk_out(input logic [2:0] c, input logic [1:0] r);
		chk({29'h0, contact}, {29'h0, c});
		chk({30'h0, range_id_o}, {30'h0, r});
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		end_of_test();
	end

	initial
	begin
		miscompares = 0;
		compares = 0;
		arst_n_i = 1'b0;
		hsel_i = 1'b0;
		haddr_i = 32'h0;
		htrans_i = 2'h0;
		hwrite_i = 1'b0;
		hwdata_i = 32'h0;
		conc_i = 24'h0;
		conc_valid_i = 1'b0;
		cell_fail_i = 1'b0;
		repeat (6) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd_chk(`CAA_OFF_CTRL, 32'h0);
		rd_chk(`CAA_OFF_AL1_SP, 32'h3e8);
		rd_chk(`CAA_OFF_AL2_CFG, 32'h0);
		rd_chk(`CAA_OFF_RNG_LO, 32'h64);
		rd_chk(`CAA_OFF_RNG_MID, 32'h3e8);
		rd_chk(`CAA_OFF_RNG_TOP, 32'h2710);
		rd_chk(8'h30, 32'h0);
		// Alarm two: below direction, failsafe relay
		wr(`CAA_OFF_AL2_CFG, 32'h5);
		smp(24'd1001);
		chk_out(3'h7, 2'h1);
		chk({8'h0, conc_o}, 32'd1001);
		smp(24'd500);
		chk_out(3'h4, 2'h1);
		chk({16'h0, aout_o}, 32'h8000);
		chk({21'h0, mv}, 32'd500);
		smp(24'd20000);
		chk({30'h0, range_id_o}, 32'h2);
		smp(24'd50);
		chk({30'h0, range_id_o}, 32'h1);
		smp(24'd50);
		chk({30'h0, range_id_o}, 32'h0);
		chk({16'h0, aout_o}, 32'h8000);
		// Latched alarm one, cleared by defeat toggle then latch toggle
		wr(`CAA_OFF_AL1_CFG, 32'h8);
		smp(24'd2000);
		chk({29'h0, contact}, 32'h7);
		smp(24'd500);
		chk({29'h0, contact}, 32'h5);
		wr(`CAA_OFF_AL1_CFG, 32'ha);
		wr(`CAA_OFF_AL1_CFG, 32'h8);
		smp(24'd500);
		chk({29'h0, contact}, 32'h4);
		smp(24'd2000);
		wr(`CAA_OFF_AL1_CFG, 32'h0);
		wr(`CAA_OFF_AL1_CFG, 32'h8);
		smp(24'd500);
		chk({29'h0, contact}, 32'h4);
		wr(`CAA_OFF_AL1_CFG, 32'h2);
		smp(24'd2000);
		chk({29'h0, contact}, 32'h6);
		// Every forced range overflows and saturates
		for (int m = 1; m < 4; m++)
		begin
			wr(`CAA_OFF_CTRL, 32'(m));
			smp(24'd20000);
			chk({30'h0, range_id_o}, 32'(m - 1));
			chk({31'h0, aout_sat_o}, 32'h1);
			chk({21'h0, mv}, 32'h3e8);
			chk({8'h0, conc_o}, 32'd20000);
		end
		wr(`CAA_OFF_RNG_TOP, 32'h1f4);
		rd_chk(`CAA_OFF_RNG_TOP, 32'h2710);
		bus(1'b0, `CAA_OFF_STATUS, 32'h0);
		chk({31'h0, rd[8]}, 32'h1);
		wr(`CAA_OFF_RNG_LO, 32'h32);
		rd_chk(`CAA_OFF_RNG_LO, 32'h32);
		wr(`CAA_OFF_CTRL, 32'h1);
		smp(24'd25);
		chk({16'h0, aout_o}, 32'h8000);
		wr(`CAA_OFF_CTRL, 32'h4);
		smp(24'd20000);
		chk({30'h0, range_id_o}, 32'h3);
		chk({16'h0, aout_o}, 32'h147a);
		// Cell failure drops the system relay until standby cycles
		@(posedge clk_i);
		cell_fail_i <= 1'b1;
		@(posedge clk_i);
		cell_fail_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		chk({31'h0, rly_sys}, 32'h0);
		wr(`CAA_OFF_CTRL, 32'h8);
		wr(`CAA_OFF_CTRL, 32'h0);
		repeat (3) @(posedge clk_i);
		#1;
		chk({31'h0, rly_sys}, 32'h1);
		end_of_test();
	end

endmodule
